/* File: rtl/fault_status_flag_bank.sv */
// fault status flag bank: two 16-bit words of sticky fault flags
// assumes upstream event pulses and table levels are synchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "fault_flag_defines.svh"
module fault_status_flag_bank
  import fault_flag_pkg::*;
#(
  parameter int WORD_BITS = `FLAG_WORD_BITS
) (
  // clock and reset
  input  wire logic           clk,
  input  wire logic           rst,
  // upstream fault sources
  input  var  fault_events_s  events,
  input  var  check_results_s checks,
  // fault table occupancy levels
  input  wire logic           sys_table_has_entries,
  input  wire logic           io_table_has_entries,
  // application access
  input  var  flag_write_s    app_write,
  output flag_word_t          sb_word,
  output flag_word_t          sc_word,
  output status_flags_s       flags
);

  // ****************************************************************
  // layout
  // ****************************************************************
  localparam int TOTAL_BITS = 2 * WORD_BITS;
  localparam int SC_BASE    = WORD_BITS;
  localparam logic [31:0] IMPL_MASK = {`SC_IMPL_MASK, `SB_IMPL_MASK};

  logic [TOTAL_BITS-1:0] set_vec;
  logic [TOTAL_BITS-1:0] clr_vec;
  logic [TOTAL_BITS-1:0] wr_vec;
  logic [TOTAL_BITS-1:0] wr_data_vec;
  logic [TOTAL_BITS-1:0] flag_vec;

  // ****************************************************************
  // table occupancy
  // ****************************************************************
  logic [2:0] watch_in;
  logic [2:0] watch_q;
  logic [2:0] watch_emptied;
  logic       sys_nonempty;
  logic       io_nonempty;
  logic       sys_emptied;
  logic       io_emptied;
  logic       both_emptied;

  assign watch_in = {sys_table_has_entries | io_table_has_entries,
                     io_table_has_entries,
                     sys_table_has_entries};

  genvar w;
  generate
    for (w = 0; w < 3; w = w + 1) begin : g_watch
      table_watch u_watch (
        .clk        (clk),
        .rst        (rst),
        .nonempty   (watch_in[w]),
        .nonempty_q (watch_q[w]),
        .emptied    (watch_emptied[w])
      );
    end
  endgenerate

  assign sys_nonempty = watch_q[0];
  assign io_nonempty  = watch_q[1];
  assign sys_emptied  = watch_emptied[0];
  assign io_emptied   = watch_emptied[1];
  // pulse on the cycle the last remaining entry across both tables goes
  assign both_emptied = watch_emptied[2];

  // ****************************************************************
  // fault summary
  // ****************************************************************
  logic any_fault_event;

  // faults that never reach a table still count as a fault here
  assign any_fault_event = events.password_violation |
                           events.cpu_software_error |
                           events.hardware_fault |
                           events.software_fault |
                           events.sys_entry_added |
                           events.io_entry_added;

  // ****************************************************************
  // set and clear requests per flag
  // ****************************************************************
  always_comb begin
    set_vec = '0;
    clr_vec = '0;

    set_vec[`SB_CORRUPTED_MEMORY] = checks.powerup_check_done &
                                    checks.powerup_memory_bad;  // [R1]
    clr_vec[`SB_CORRUPTED_MEMORY] = checks.powerup_check_done &
                                    ~checks.powerup_memory_bad; // [R1]

    set_vec[`SB_PASSWORD_VIOL] = events.password_violation;     // [R2]
    clr_vec[`SB_PASSWORD_VIOL] = events.sys_table_cleared;      // [R2]

    set_vec[`SB_CPU_SW_ERROR] = events.cpu_software_error;      // [R3]
    clr_vec[`SB_CPU_SW_ERROR] = events.sys_table_cleared;       // [R3]

    set_vec[`SB_STORE_ERROR] = checks.store_done & ~checks.store_ok; // [R4]
    clr_vec[`SB_STORE_ERROR] = checks.store_done & checks.store_ok;  // [R4]

    set_vec[SC_BASE + `SC_ANY_FAULT] = any_fault_event;         // [R5]
    clr_vec[SC_BASE + `SC_ANY_FAULT] = both_emptied;            // [R5]

    set_vec[SC_BASE + `SC_SYS_LOGGED] = events.sys_entry_added; // [R6]
    clr_vec[SC_BASE + `SC_SYS_LOGGED] = sys_emptied;            // [R6]

    set_vec[SC_BASE + `SC_IO_LOGGED] = events.io_entry_added;   // [R7]
    clr_vec[SC_BASE + `SC_IO_LOGGED] = io_emptied;              // [R7]

    // occupancy flags follow the level; a write lasts one cycle at most
    set_vec[SC_BASE + `SC_SYS_NONEMPTY] = sys_nonempty;         // [R8]
    clr_vec[SC_BASE + `SC_SYS_NONEMPTY] = ~sys_nonempty;        // [R8]

    set_vec[SC_BASE + `SC_IO_NONEMPTY] = io_nonempty;           // [R9]
    clr_vec[SC_BASE + `SC_IO_NONEMPTY] = ~io_nonempty;          // [R9]

    set_vec[SC_BASE + `SC_HW_FAULT] = events.hardware_fault;    // [R10]
    clr_vec[SC_BASE + `SC_HW_FAULT] = both_emptied;             // [R10]

    set_vec[SC_BASE + `SC_SW_FAULT] = events.software_fault;    // [R11]
    clr_vec[SC_BASE + `SC_SW_FAULT] = both_emptied;             // [R11]
  end

  // ****************************************************************
  // application write steering
  // ****************************************************************
  always_comb begin
    wr_vec      = '0;
    wr_data_vec = {app_write.data, app_write.data};
    if (app_write.en && app_write.group == GROUP_SB) begin
      wr_vec[WORD_BITS-1:0] = {WORD_BITS{1'b1}};              // [R12]
    end else if (app_write.en && app_write.group == GROUP_SC) begin
      wr_vec[TOTAL_BITS-1:SC_BASE] = {WORD_BITS{1'b1}};       // [R12]
    end
  end

  // ****************************************************************
  // flag storage, one cell per implemented position
  // ****************************************************************
  genvar b;
  generate
    for (b = 0; b < TOTAL_BITS; b = b + 1) begin : g_flag
      if (IMPL_MASK[b]) begin : g_impl
        flag_cell u_cell (
          .clk    (clk),
          .rst    (rst),
          .set    (set_vec[b]),
          .clr    (clr_vec[b]),
          .wr_en  (wr_vec[b]),
          .wr_val (wr_data_vec[b]),
          .q      (flag_vec[b])
        );
      end else begin : g_resv
        // reserved positions hold no state at all
        assign flag_vec[b] = 1'b0;                            // [R13]
      end
    end
  endgenerate

  // ****************************************************************
  // read side
  // ****************************************************************
  assign sb_word = flag_vec[WORD_BITS-1:0] & `SB_IMPL_MASK;       // [R13]
  assign sc_word = flag_vec[TOTAL_BITS-1:SC_BASE] & `SC_IMPL_MASK; // [R13]

  assign flags.corrupted_memory_flag    = sb_word[`SB_CORRUPTED_MEMORY];
  assign flags.password_violation_flag  = sb_word[`SB_PASSWORD_VIOL];
  assign flags.cpu_software_error_flag  = sb_word[`SB_CPU_SW_ERROR];
  assign flags.store_error_flag         = sb_word[`SB_STORE_ERROR];
  assign flags.any_fault_flag           = sc_word[`SC_ANY_FAULT];
  assign flags.system_fault_logged_flag = sc_word[`SC_SYS_LOGGED];
  assign flags.io_fault_logged_flag     = sc_word[`SC_IO_LOGGED];
  assign flags.system_table_nonempty    = sc_word[`SC_SYS_NONEMPTY];
  assign flags.io_table_nonempty        = sc_word[`SC_IO_NONEMPTY];
  assign flags.hardware_fault_flag      = sc_word[`SC_HW_FAULT];
  assign flags.software_fault_flag      = sc_word[`SC_SW_FAULT];

endmodule
`default_nettype wire

/* File: rtl/fault_flag_defines.svh */
// fault flag bank constants: word layout, flag positions, reset values
// assumes the including file uses the numbered flag positions below
//
// Contract
// R1: powerup memory check sets or clears corruption flag
// R2: password violation sets flag until system table clear
// R3: software error flag cleared by system table clear or by an application write of zero to the first word
// R4: store error set on failure, cleared on success
// R5: any fault sets; clears when both tables empty
// R6: system entry sets; clears when system table empty
// R7: io entry sets; clears when io table empty
// R8: system nonempty flag follows system table occupancy
// R9: io nonempty flag follows io table occupancy
// R10: hardware fault sets; clears when both tables empty
// R11: software fault sets; clears when both tables empty
// R12: application may read and write every flag; a write to the nonempty flags lasts one cycle at most
// R13: reserved positions read zero, writes ignored
`ifndef FAULT_FLAG_DEFINES_SVH
`define FAULT_FLAG_DEFINES_SVH

// ****************************************************************
// word geometry
// ****************************************************************
`define FLAG_WORD_BITS      16
`define FLAG_RESET_WORD     16'h0000

// ****************************************************************
// first status word, bit index = reference number minus one
// ****************************************************************
`define SB_CORRUPTED_MEMORY 9
`define SB_PASSWORD_VIOL    10
`define SB_CPU_SW_ERROR     12
`define SB_STORE_ERROR      13
`define SB_IMPL_MASK        16'h3600

// ****************************************************************
// second status word
// ****************************************************************
`define SC_ANY_FAULT        8
`define SC_SYS_LOGGED       9
`define SC_IO_LOGGED        10
`define SC_SYS_NONEMPTY     11
`define SC_IO_NONEMPTY      12
`define SC_HW_FAULT         13
`define SC_SW_FAULT         14
`define SC_IMPL_MASK        16'h7F00

`endif

/* File: rtl/fault_flag_pkg.sv */
// fault flag bank types: event bundle, write request, word selector
// assumes the defines header is compiled alongside
package fault_flag_pkg;

  // ****************************************************************
  // word selector for application access
  // ****************************************************************
  typedef enum logic {
    GROUP_SB,
    GROUP_SC
  } flag_group_e;

  typedef logic [15:0] flag_word_t;

  // ****************************************************************
  // application write request, one-cycle strobe
  // ****************************************************************
  typedef struct packed {
    logic        en;
    flag_group_e group;
    flag_word_t  data;
  } flag_write_s;

  // ****************************************************************
  // upstream fault events, each a one-cycle pulse
  // ****************************************************************
  typedef struct packed {
    logic password_violation;
    logic cpu_software_error;
    logic hardware_fault;
    logic software_fault;
    logic sys_entry_added;
    logic io_entry_added;
    logic sys_table_cleared;
  } fault_events_s;

  // ****************************************************************
  // check results: done strobes with their outcome levels
  // ****************************************************************
  typedef struct packed {
    logic powerup_check_done;
    logic powerup_memory_bad;
    logic store_done;
    logic store_ok;
  } check_results_s;

  // ****************************************************************
  // named view of the implemented flags
  // ****************************************************************
  typedef struct packed {
    logic corrupted_memory_flag;
    logic password_violation_flag;
    logic cpu_software_error_flag;
    logic store_error_flag;
    logic any_fault_flag;
    logic system_fault_logged_flag;
    logic io_fault_logged_flag;
    logic system_table_nonempty;
    logic io_table_nonempty;
    logic hardware_fault_flag;
    logic software_fault_flag;
  } status_flags_s;

endpackage

/* File: rtl/flag_cell.sv */
// one sticky status flag with set, application write and clear
// assumes set, clear and write are synchronous one-cycle requests
`timescale 1ns/1ps
`default_nettype none
module flag_cell (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // requests
  input  wire logic set,
  input  wire logic clr,
  input  wire logic wr_en,
  input  wire logic wr_val,
  // state
  output logic      q
);

  logic flag_reg;
  logic flag_next;

  // set beats write beats clear, so no event is lost to a clear
  always_comb begin
    flag_next = flag_reg;
    if (set) begin
      flag_next = 1'b1;
    end else if (wr_en) begin
      flag_next = wr_val;
    end else if (clr) begin
      flag_next = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign q = flag_reg;

endmodule
`default_nettype wire

/* File: rtl/table_watch.sv */
// occupancy tracker for one fault table
// assumes nonempty is a synchronous level from the table logic
`timescale 1ns/1ps
`default_nettype none
module table_watch (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // occupancy in
  input  wire logic nonempty,
  // occupancy out
  output logic      nonempty_q,
  output logic      emptied
);

  logic seen_reg;
  logic seen_next;

  // tables are taken as empty after reset, so no false emptied pulse
  always_comb begin
    seen_next = nonempty;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seen_reg <= 1'b0;
    end else begin
      seen_reg <= seen_next;
    end
  end

  assign nonempty_q = seen_reg;
  assign emptied    = seen_reg & ~nonempty;

endmodule
`default_nettype wire

/* File: test/fault_status_flag_bank_monitor.sv */
// checker for the fault flag bank, watching only its top ports
// assumes one clock domain with asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module fault_status_flag_bank_monitor
  import fault_flag_pkg::*;
#(
  parameter int WORD_BITS = 16
) (
  // clock and reset
  input wire logic           clk,
  input wire logic           rst,
  // sources
  input var  fault_events_s  events,
  input var  check_results_s checks,
  input wire logic           sys_table_has_entries,
  input wire logic           io_table_has_entries,
  input var  flag_write_s    app_write,
  // flag words
  input var  flag_word_t     sb_word,
  input var  flag_word_t     sc_word,
  input var  status_flags_s  flags
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // tracking sets beat writes and writes beat its clears, so writes are kept out of it
  logic sc_wr;
  assign sc_wr = app_write.en && (app_write.group == GROUP_SC);

  a_sb_reserved: assert property ((sb_word & 16'hC9FF) == 16'h0000)
    else $error("reserved bit set in first word");
  a_sc_reserved: assert property ((sc_word & 16'h80FF) == 16'h0000)
    else $error("reserved bit set in second word");
  a_mem_bad: assert property (checks.powerup_check_done && checks.powerup_memory_bad
    |=> sb_word[9]) else $error("memory flag not set");
  a_mem_good: assert property (checks.powerup_check_done && !checks.powerup_memory_bad
    && !app_write.en |=> !sb_word[9]) else $error("memory flag not cleared");
  a_pwd_set: assert property (events.password_violation |=> sb_word[10] && sc_word[8])
    else $error("password flag not set");
  a_cpu_hold: assert property (sb_word[12] && !events.sys_table_cleared
    && !app_write.en |=> sb_word[12]) else $error("cpu error flag lost");
  a_store_fail: assert property (checks.store_done && !checks.store_ok |=> sb_word[13])
    else $error("store error flag not set");
  a_store_pass: assert property (checks.store_done && checks.store_ok
    && !app_write.en |=> !sb_word[13]) else $error("store error flag not cleared");
  a_any_fault: assert property ((|events[6:1]) |=> sc_word[8])
    else $error("any fault flag not set");
  a_entry_logged: assert property ((events.sys_entry_added |=> sc_word[9])
    and (events.io_entry_added |=> sc_word[10])) else $error("logged flag not set");
  a_kind_set: assert property ((events.hardware_fault |=> sc_word[13])
    and (events.software_fault |=> sc_word[14])) else $error("fault kind flag not set");
  a_sys_track: assert property ((sys_table_has_entries && !sc_wr)[*2] |=> sc_word[11])
    else $error("system nonempty flag low");
  a_io_track: assert property ((io_table_has_entries && !sc_wr)[*2] |=> sc_word[12])
    else $error("io nonempty flag low");
  a_view_match: assert property (flags == {sb_word[9], sb_word[10], sb_word[12],
    sb_word[13], sc_word[8], sc_word[9], sc_word[10], sc_word[11], sc_word[12],
    sc_word[13], sc_word[14]}) else $error("named flags differ from words");
endmodule

bind fault_status_flag_bank fault_status_flag_bank_monitor #(.WORD_BITS(WORD_BITS)) u_mon (
  .clk(clk), .rst(rst), .events(events), .checks(checks),
  .sys_table_has_entries(sys_table_has_entries), .io_table_has_entries(io_table_has_entries),
  .app_write(app_write), .sb_word(sb_word), .sc_word(sc_word), .flags(flags));
`default_nettype wire

/* File: test/fault_status_flag_bank_tb_top.sv */
// directed bench for the fault flag bank
// assumes the flag defines header is on the include path
`timescale 1ns/1ps
`default_nettype none
`include "fault_flag_defines.svh"
module fault_status_flag_bank_tb_top import fault_flag_pkg::*;;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic           clk = 1'b0;
  logic           rst = 1'b1;
  fault_events_s  events = '0;
  check_results_s checks = '0;
  logic           sys_lvl = 1'b0;
  logic           io_lvl = 1'b0;
  flag_write_s    app_write = '0;
  flag_word_t     sb_word;
  flag_word_t     sc_word;
  status_flags_s  flags;
  int             n_errors = 0;
  int             cmp_count = 0;

  always #50 clk = ~clk;

  fault_status_flag_bank dut (
    .clk(clk), .rst(rst), .events(events), .checks(checks),
    .sys_table_has_entries(sys_lvl), .io_table_has_entries(io_lvl),
    .app_write(app_write), .sb_word(sb_word), .sc_word(sc_word), .flags(flags));

  // ****************************************************************
  // tasks: one request per call, an idle cycle after each
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic go();
    tick(1);
    events = '0;
    checks = '0;
    app_write = '0;
    tick(1);
  endtask
  task automatic ev(input fault_events_s e);
    events = e;
    go();
  endtask
  task automatic ck(input check_results_s c);
    checks = c;
    go();
  endtask
  task automatic wr(input flag_group_e g, input flag_word_t d);
    app_write = {1'b1, g, d};
    go();
  endtask
  task automatic lv(input logic s, input logic i, input fault_events_s e);
    sys_lvl = s;
    io_lvl = i;
    events = e;
    go();
  endtask
  task automatic chk(input flag_word_t seen, input flag_word_t exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t word %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // sequence
  // ****************************************************************
  // watchdog: the sequence is under fifty cycles long
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    summarize();
  end

  initial begin
    tick(3);
    rst = 1'b0;
    chk(sb_word, 16'h0000);
    chk(sc_word, 16'h0000);
    ck(4'hC); chk(sb_word, 16'h0200);
    ck(4'h8); chk(sb_word, 16'h0000);
    wr(GROUP_SB, 16'hFFFF); chk(sb_word, `SB_IMPL_MASK);
    wr(GROUP_SB, 16'h0000); chk(sb_word, 16'h0000);
    // nonempty bits fall back since both tables are empty
    wr(GROUP_SC, 16'hFFFF); chk(sc_word, 16'h6700);
    wr(GROUP_SC, 16'h0000); chk(sc_word, 16'h0000);
    ev(7'h40); chk(sb_word, 16'h0400);
    chk(sc_word, 16'h0100);
    tick(3); chk(sb_word, 16'h0400);
    ev(7'h01); chk(sb_word, 16'h0000);
    chk(sc_word, 16'h0100);
    wr(GROUP_SC, 16'h0000);
    ev(7'h20); ck(4'h3); chk(sb_word, 16'h1000);
    ev(7'h01); chk(sb_word, 16'h0000);
    ck(4'h2); chk(sb_word, 16'h2000);
    ck(4'h3); chk(sb_word, 16'h0000);
    wr(GROUP_SC, 16'h0000);
    // nonempty flag lands two edges after the level, inside the call
    lv(1'b1, 1'b0, 7'h14); chk(sc_word, 16'h2B00);
    tick(1); chk(sc_word, 16'h2B00);
    lv(1'b1, 1'b1, 7'h0A); chk(sc_word, 16'h7F00);
    tick(1); chk(sc_word, 16'h7F00);
    chk({5'h00, flags}, 16'h007F);
    lv(1'b0, 1'b1, 7'h00); chk(sc_word, 16'h7500);
    lv(1'b0, 1'b0, 7'h00); chk(sc_word, 16'h0000);
    summarize();
  end
endmodule
`default_nettype wire
